// *** pkg/jttl_params.svh ***
`ifndef JTTL_PARAMS_SVH
`define JTTL_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define JTTL_REG_CTRL 4'h0
`define JTTL_REG_KCFG 4'h4
`define JTTL_REG_STAT 4'h8

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define JTTL_CTRL_EN 0
`define JTTL_CTRL_SCR 1
`define JTTL_CTRL_FMT 4
`define JTTL_KCFG_RST 8'h1f
`define JTTL_STAT_CNT 16

// ------------------------------------------------------------
// Multiframe limits, in octets per multiframe
// ------------------------------------------------------------
`define JTTL_MF_MIN_OCT 12'd17
`define JTTL_MF_MAX_OCT 12'd1024

// ------------------------------------------------------------
// Control octets ahead of the line encoder, and index of the last alignment multiframe
// ------------------------------------------------------------
`define JTTL_K28_0 8'h1c
`define JTTL_K28_3 8'h7c
`define JTTL_K28_4 8'h9c
`define JTTL_K28_5 8'hbc
`define JTTL_ILAS_LAST 2'h3

// ------------------------------------------------------------
// Sample slots and 64b/66b framing
// ------------------------------------------------------------
`define JTTL_NPRIME 16
`define JTTL_SH_DATA 2'b01
`define JTTL_EMB_OCT 12'd256

`endif

// *** pkg/jttl_pkg.sv ***
package jttl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CGS,
    ST_WAIT_LMFC,
    ST_ILAS,
    ST_DATA
  } jttl_state_e;

  typedef struct packed {
    logic [2:0] lanes;
    logic [3:0] octets;
    logic [1:0] fShift;
    logic enc64;
  } jttl_mode_s;

  // Format 0: L4 F2 M4 S1, 1: L2 F4 M2 S2, 2: L1 F8 M4 S1,
  // 3: as format 0 over 64b/66b
  function automatic jttl_mode_s jttl_mode_decode(input logic [1:0] fmt);
    jttl_mode_s m;
    m = '{lanes: 3'd4, octets: 4'd2, fShift: 2'd1, enc64: 1'b0};
    if (fmt == 2'd1) begin
      m = '{lanes: 3'd2, octets: 4'd4, fShift: 2'd2, enc64: 1'b0};
    end else if (fmt == 2'd2) begin
      m = '{lanes: 3'd1, octets: 4'd8, fShift: 2'd3, enc64: 1'b0};
    end else if (fmt == 2'd3) begin
      m.enc64 = 1'b1;
    end
    return m;
  endfunction

endpackage

// *** hw/jttl_scrambler.sv ***
`timescale 1ns/10ps
// Self-synchronous scrambler, 1 + x^TA + x^TB, MSB scrambled first
module jttl_scrambler #(
  parameter int W = 8,
  parameter int SL = 15,
  parameter int TA = 14,
  parameter int TB = 15
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] dataIn,
  input wire logic advance,
  output logic [W-1:0] dataOut
);
  logic [SL-1:0] hist;
  logic [SL-1:0] next_hist;

  always_comb begin
    next_hist = hist;
    for (int i = W - 1; i >= 0; i--) begin
      dataOut[i] = dataIn[i] ^ next_hist[TA-1] ^ next_hist[TB-1];
      next_hist = {next_hist[SL-2:0], dataOut[i]};
    end
  end

  // History only moves on scrambled words so the far end stays locked
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hist <= '1;
    end else if (advance) begin
      hist <= next_hist;
    end
  end
endmodule

// *** hw/jttl_enc8b10b.sv ***
`timescale 1ns/10ps
// One lane of 8b/10b; output abcdei fghj with a in bit 9
module jttl_enc8b10b (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Octet in
  input wire logic [7:0] octet,
  input wire logic isK,
  input wire logic advance,
  // Character out
  output logic [9:0] code
);
  logic rdPos;
  logic next_rdPos;
  logic rdMid;
  logic [5:0] t6;
  logic [5:0] c6;
  logic [3:0] t4;
  logic [3:0] c4;
  logic [4:0] x;
  logic [2:0] y;

  assign x = octet[4:0];
  assign y = octet[7:5];

  always_comb begin
    case (x)
      5'h00: t6 = 6'b100111;
      5'h01: t6 = 6'b011101;
      5'h02: t6 = 6'b101101;
      5'h03: t6 = 6'b110001;
      5'h04: t6 = 6'b110101;
      5'h05: t6 = 6'b101001;
      5'h06: t6 = 6'b011001;
      5'h07: t6 = 6'b111000;
      5'h08: t6 = 6'b111001;
      5'h09: t6 = 6'b100101;
      5'h0a: t6 = 6'b010101;
      5'h0b: t6 = 6'b110100;
      5'h0c: t6 = 6'b001101;
      5'h0d: t6 = 6'b101100;
      5'h0e: t6 = 6'b011100;
      5'h0f: t6 = 6'b010111;
      5'h10: t6 = 6'b011011;
      5'h11: t6 = 6'b100011;
      5'h12: t6 = 6'b010011;
      5'h13: t6 = 6'b110010;
      5'h14: t6 = 6'b001011;
      5'h15: t6 = 6'b101010;
      5'h16: t6 = 6'b011010;
      5'h17: t6 = 6'b111010;
      5'h18: t6 = 6'b110011;
      5'h19: t6 = 6'b100110;
      5'h1a: t6 = 6'b010110;
      5'h1b: t6 = 6'b110110;
      5'h1c: t6 = 6'b001110;
      5'h1d: t6 = 6'b101110;
      5'h1e: t6 = 6'b011110;
      default: t6 = 6'b101011;
    endcase
    // Only K28.y control characters are ever requested
    if (isK) begin
      t6 = 6'b001111;
    end
    c6 = t6;
    rdMid = rdPos;
    if ($countones(t6) != 3) begin
      c6 = rdPos ? ~t6 : t6;
      rdMid = ~rdPos;
    end else if (t6 == 6'b111000) begin
      c6 = rdPos ? 6'b000111 : t6;
    end
    case (y)
      3'h0: t4 = 4'b1011;
      3'h1: t4 = 4'b1001;
      3'h2: t4 = 4'b0101;
      3'h3: t4 = 4'b1100;
      3'h4: t4 = 4'b1101;
      3'h5: t4 = 4'b1010;
      3'h6: t4 = 4'b0110;
      default: t4 = 4'b1110;
    endcase
    // Alternate y=7 avoids a run of five equal bits
    if (y == 3'h7 && (isK ||
        (!rdMid && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
        (rdMid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)))) begin
      t4 = 4'b0111;
    end
    c4 = t4;
    next_rdPos = rdMid;
    if ($countones(t4) != 2) begin
      c4 = rdMid ? ~t4 : t4;
      next_rdPos = ~rdMid;
    end else if (y == 3'h3) begin
      c4 = rdMid ? ~t4 : t4;
    end else if (isK) begin
      c4 = rdMid ? t4 : ~t4;
    end
    code = {c6, c4};
  end

  // Running disparity of this lane alone
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdPos <= 1'b0;
    end else if (advance) begin
      rdPos <= next_rdPos;
    end
  end
endmodule

// *** hw/jttl_tx_link.sv ***
`timescale 1ns/10ps
`include "jttl_params.svh"

// Functional notes
// - Samples become octets, frames, then lanes
// - F octets carry S samples of M converters
// - One format select fixes whole transport setup
// - Build multiframes, or blocks and multiblocks
// - 8b/10b scrambles only when enabled
// - 64b/66b always scrambles
// - 8b/10b scrambles octets before encoding
// - 64b/66b scrambles block, then adds header
// - Alignment sequence is never scrambled
// - Separate polynomial per encoding scheme
// - Octets encoded to DC-balanced 10-bit characters
// - K limited by F; invalid K blocks link
// - SYSREF resets multiframe counter phase
// - Multiframe clock spans F times K characters
// - SYNC timing as earlier standard
// - SYNC low sends commas; high after four
// - After SYNC rise, wait edge, four-multiframe alignment
module jttl_tx_link
  import jttl_pkg::*;
#(
  parameter int NL = 4,
  parameter int NBITS = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sample stream, four slots of NBITS in 16-bit fields
  input wire logic [63:0] sampleData,
  output logic sampleReady,
  // Link control pins
  input wire logic sync_n,
  input wire logic sysref,
  // Lane outputs
  output logic [NL*10-1:0] laneChar,
  output logic [NL*66-1:0] laneBlock,
  output logic blockValid,
  output logic multiblockStart,
  output logic lmfcEdge
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [2:0] syncPipe;
  logic [2:0] refPipe;
  logic syncLevel;
  logic refLevel;
  logic syncRise;
  logic sysrefRise;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncPipe <= 3'h7;
      refPipe <= 3'h0;
    end else begin
      syncPipe <= {syncPipe[1:0], sync_n};
      refPipe <= {refPipe[1:0], sysref};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      syncLevel <= 1'b1;
      refLevel <= 1'b0;
    end else begin
      if (syncPipe[1] == syncPipe[2]) begin
        syncLevel <= syncPipe[2];
      end
      if (refPipe[1] == refPipe[2]) begin
        refLevel <= refPipe[2];
      end
    end
  end

  assign syncRise = syncPipe[1] && syncPipe[2] && !syncLevel;
  assign sysrefRise = refPipe[1] && refPipe[2] && !refLevel;

  // ----------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------
  logic busAck;
  logic linkEn;
  logic scrEn;
  logic [1:0] fmtSel;
  logic [7:0] kMinus1;
  logic kValid;
  logic [9:0] lmfcCnt;
  jttl_state_e state;
  jttl_mode_s mode;

  // One wait state on every access
  assign avs_waitrequest = (avs_read || avs_write) && !busAck;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busAck <= 1'b0;
    end else begin
      busAck <= (avs_read || avs_write) && !busAck;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      linkEn <= 1'b0;
      scrEn <= 1'b0;
      fmtSel <= 2'h0;
      kMinus1 <= `JTTL_KCFG_RST;
    end else if (avs_write && busAck) begin
      if (avs_address == `JTTL_REG_CTRL) begin
        linkEn <= avs_writedata[`JTTL_CTRL_EN];
        scrEn <= avs_writedata[`JTTL_CTRL_SCR];
        fmtSel <= avs_writedata[`JTTL_CTRL_FMT +: 2];
      end else if (avs_address == `JTTL_REG_KCFG) begin
        kMinus1 <= avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !busAck) begin
      if (avs_address == `JTTL_REG_CTRL) begin
        avs_readdata <= {26'h0, fmtSel, 2'h0, scrEn, linkEn};
      end else if (avs_address == `JTTL_REG_KCFG) begin
        avs_readdata <= {24'h0, kMinus1};
      end else if (avs_address == `JTTL_REG_STAT) begin
        avs_readdata <= {6'h0, lmfcCnt, 10'h0, mode.enc64, kValid,
                         syncLevel, state};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------
  // Transport mode and multiframe length
  // ----------------------------------------------------------
  logic [11:0] mfOct;
  logic [11:0] period;
  logic [9:0] lastIdx;
  logic lmfcWrap;
  logic [2:0] octIdx;

  assign mode = jttl_mode_decode(fmtSel);
  assign mfOct = 12'(({4'h0, kMinus1} + 12'd1) << mode.fShift);
  assign kValid = mode.enc64 || (mfOct >= `JTTL_MF_MIN_OCT &&
                  mfOct <= `JTTL_MF_MAX_OCT);
  assign period = mode.enc64 ? `JTTL_EMB_OCT : mfOct;
  assign lastIdx = 10'(period - 12'd1);
  assign lmfcWrap = lmfcCnt == lastIdx;
  assign octIdx = lmfcCnt[2:0] & 3'(mode.octets - 4'd1);

  // ----------------------------------------------------------
  // Local multiframe / extended multiblock counter
  // ----------------------------------------------------------
  // One character per clock, so a period is F*K clocks, or 256 in 64b/66b
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lmfcCnt <= 10'h0;
    end else if (sysrefRise) begin
      lmfcCnt <= 10'h0;
    end else if (lmfcWrap) begin
      lmfcCnt <= 10'h0;
    end else begin
      lmfcCnt <= lmfcCnt + 10'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lmfcEdge <= 1'b0;
    end else begin
      lmfcEdge <= sysrefRise || lmfcWrap;
    end
  end

  // ----------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------
  logic [1:0] ilasMf;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else if (!linkEn || !kValid) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          state <= mode.enc64 ? ST_WAIT_LMFC : ST_CGS;
        end
        ST_CGS: begin
          if (syncRise) begin
            state <= ST_WAIT_LMFC;
          end
        end
        ST_WAIT_LMFC: begin
          if (!mode.enc64 && !syncLevel) begin
            state <= ST_CGS;
          end else if (lmfcWrap) begin
            state <= mode.enc64 ? ST_DATA : ST_ILAS;
          end
        end
        ST_ILAS: begin
          if (!syncLevel) begin
            state <= ST_CGS;
          end else if (lmfcWrap && ilasMf == `JTTL_ILAS_LAST) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (!mode.enc64 && !syncLevel) begin
            state <= ST_CGS;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ilasMf <= 2'h0;
    end else if (state != ST_ILAS) begin
      ilasMf <= 2'h0;
    end else if (lmfcWrap) begin
      ilasMf <= ilasMf + 2'h1;
    end
  end

  // ----------------------------------------------------------
  // Transport packing
  // ----------------------------------------------------------
  logic [63:0] packedFrame;
  logic [63:0] frameReg;
  logic [63:0] curFrame;
  logic scr8Adv;
  logic blkEnd;

  function automatic logic [7:0] laneByte(input logic [63:0] f,
                                          input logic [2:0] j);
    return f[63 - 8 * j -: 8];
  endfunction

  // Each sample sits MSB-aligned in its N' field, tail bits zero
  always_comb begin
    packedFrame = 64'h0;
    for (int s = 0; s < 4; s++) begin
      packedFrame[63 - `JTTL_NPRIME * s -: `JTTL_NPRIME] =
        {sampleData[`JTTL_NPRIME * s +: NBITS],
         {(`JTTL_NPRIME - NBITS){1'b0}}};
    end
  end

  assign sampleReady = octIdx == 3'h0;
  assign curFrame = sampleReady ? packedFrame : frameReg;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      frameReg <= 64'h0;
    end else if (sampleReady) begin
      frameReg <= packedFrame;
    end
  end

  assign scr8Adv = state == ST_DATA && !mode.enc64 && scrEn;
  assign blkEnd = mode.enc64 && state == ST_DATA && lmfcCnt[2:0] == 3'h7;

  // ----------------------------------------------------------
  // Lanes
  // ----------------------------------------------------------
  for (genvar l = 0; l < NL; l++) begin : g_lane
    logic [2:0] byteSel;
    logic [7:0] dataOct;
    logic [7:0] scr8Out;
    logic [7:0] txOct;
    logic txK;
    logic [9:0] encChar;
    logic [63:0] blkAcc;
    logic [63:0] blkFull;
    logic [63:0] scr64Out;
    logic active;

    assign active = l < mode.lanes;
    assign byteSel = 3'(l << mode.fShift) | octIdx;
    assign dataOct = laneByte(curFrame, byteSel);

    jttl_scrambler #(.W(8), .SL(15), .TA(14), .TB(15)) u_scr8 (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .dataIn(dataOct),
      .advance(scr8Adv),
      .dataOut(scr8Out)
    );

    // Commas outside alignment and data, markers on multiframe ends
    always_comb begin
      txK = 1'b1;
      txOct = `JTTL_K28_5;
      if (state == ST_ILAS) begin
        txK = 1'b0;
        txOct = lmfcCnt[7:0];
        if (lmfcCnt == 10'h0) begin
          txK = 1'b1;
          txOct = `JTTL_K28_0;
        end else if (lmfcWrap) begin
          txK = 1'b1;
          txOct = `JTTL_K28_3;
        end else if (ilasMf == 2'h1 && lmfcCnt == 10'h1) begin
          txK = 1'b1;
          txOct = `JTTL_K28_4;
        end
      end else if (state == ST_DATA) begin
        txK = 1'b0;
        txOct = scrEn ? scr8Out : dataOct;
      end
    end

    jttl_enc8b10b u_enc (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .octet(txOct),
      .isK(txK),
      .advance(!mode.enc64),
      .code(encChar)
    );

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        laneChar[l*10 +: 10] <= 10'h0;
      end else begin
        laneChar[l*10 +: 10] <= (active && !mode.enc64) ? encChar : 10'h0;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        blkAcc <= 64'h0;
      end else begin
        blkAcc <= blkFull;
      end
    end

    assign blkFull = {blkAcc[55:0], dataOct};

    // Always scrambled, regardless of the enable bit
    jttl_scrambler #(.W(64), .SL(58), .TA(39), .TB(58)) u_scr64 (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .dataIn(blkFull),
      .advance(blkEnd),
      .dataOut(scr64Out)
    );

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        laneBlock[l*66 +: 66] <= 66'h0;
      end else if (blkEnd) begin
        laneBlock[l*66 +: 66] <= active ?
          {`JTTL_SH_DATA, scr64Out} : 66'h0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      blockValid <= 1'b0;
      multiblockStart <= 1'b0;
    end else begin
      blockValid <= blkEnd;
      multiblockStart <= blkEnd && lmfcCnt[7:3] == 5'h0;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_sysref_phase;
    sysrefRise |=> lmfcCnt == 10'h0;
  endproperty
  a_sysref_phase: assert property (p_sysref_phase)
    else $error("multiframe counter not reset by SYSREF");

  property p_lmfc_period;
    !sysrefRise && lmfcCnt == lastIdx && $stable(kMinus1) |=>
      lmfcCnt == 10'h0;
  endproperty
  a_lmfc_period: assert property (p_lmfc_period)
    else $error("multiframe counter did not wrap");

  property p_cgs_comma;
    state == ST_CGS && !mode.enc64 && $stable(fmtSel) |=>
      laneChar[9:0] == 10'b0011111010 || laneChar[9:0] == 10'b1100000101;
  endproperty
  a_cgs_comma: assert property (p_cgs_comma)
    else $error("comma not sent while sync requested");

  property p_sync_drop;
    (state == ST_ILAS || state == ST_DATA) && !syncLevel &&
      !mode.enc64 && linkEn && kValid |=> state == ST_CGS;
  endproperty
  a_sync_drop: assert property (p_sync_drop)
    else $error("link did not return to comma phase");

  property p_ilas_on_edge;
    $rose(state == ST_ILAS) |-> lmfcCnt == 10'h0;
  endproperty
  a_ilas_on_edge: assert property (p_ilas_on_edge)
    else $error("alignment did not start on multiframe edge");

  property p_ilas_first_char;
    state == ST_ILAS && lmfcCnt == 10'h0 && $stable(fmtSel) |=>
      laneChar[9:0] == 10'b0011110100 || laneChar[9:0] == 10'b1100001011;
  endproperty
  a_ilas_first_char: assert property (p_ilas_first_char)
    else $error("multiframe of alignment not opened by K28.0");

  property p_ilas_to_data;
    state == ST_ILAS && lmfcWrap && ilasMf == `JTTL_ILAS_LAST &&
      syncLevel && linkEn && kValid |=> state == ST_DATA;
  endproperty
  a_ilas_to_data: assert property (p_ilas_to_data)
    else $error("data did not follow fourth alignment multiframe");

  property p_k_range;
    !kValid |=> state == ST_IDLE;
  endproperty
  a_k_range: assert property (p_k_range)
    else $error("link left idle with invalid K");

  // Scrambler history frozen outside data, so alignment stays plain
  property p_no_scr_ilas;
    state != ST_DATA |=> $stable(g_lane[0].u_scr8.hist);
  endproperty
  a_no_scr_ilas: assert property (p_no_scr_ilas)
    else $error("scrambler advanced outside enabled data");

  property p_block_hdr;
    blockValid |-> laneBlock[65:64] == `JTTL_SH_DATA;
  endproperty
  a_block_hdr: assert property (p_block_hdr)
    else $error("block without sync header");

  property p_block_spacing;
    blockValid |=> !blockValid [*7];
  endproperty
  a_block_spacing: assert property (p_block_spacing)
    else $error("blocks closer than eight octets");

  c_cgs_exit: cover property (state == ST_CGS ##1 state == ST_WAIT_LMFC);
  c_data: cover property ($rose(state == ST_DATA) && !mode.enc64);
  c_sysref: cover property (sysrefRise);
  c_multiblock: cover property (multiblockStart);

endmodule

// *** dv/jttl_rx_model.sv ***
`timescale 1ns/10ps
// ------------------------------------------------------------
// Receiver on the far side of the lanes
// ------------------------------------------------------------
module jttl_rx_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Lane and link control
  input wire logic [9:0] laneChar0,
  input wire logic lmfcEdge,
  input wire logic linkReq,
  output logic sync_n,
  output logic sysref
);
  logic [2:0] commas;
  logic [3:0] refCnt;
  logic done;
  // One timing reference pulse after reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      refCnt <= 4'h0;
      sysref <= 1'b0;
    end else if (refCnt != 4'hf) begin
      refCnt <= refCnt + 4'h1;
      sysref <= refCnt[3];
    end else begin
      sysref <= 1'b0;
    end
  end
  // Request, count commas, release on the transmitter's multiframe edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !linkReq) begin
      sync_n <= 1'b1;
      commas <= 3'h0;
      done <= 1'b0;
    end else if (sync_n && !done) begin
      sync_n <= 1'b0;
    end else if (!sync_n) begin
      if (laneChar0 == 10'h0fa || laneChar0 == 10'h305) begin
        commas <= (commas == 3'h4) ? commas : commas + 3'h1;
      end else begin
        commas <= 3'h0;
      end
      if (commas == 3'h4 && lmfcEdge) begin
        sync_n <= 1'b1;
        done <= 1'b1;
      end
    end
  end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [63:0] sampleData = 64'h0;
  logic sampleReady;
  logic sync_n;
  logic sysref;
  logic linkReq = 1'b0;
  logic [39:0] laneChar;
  logic [263:0] laneBlock;
  logic blockValid;
  logic multiblockStart;
  logic lmfcEdge;
  logic [3:0] ev;
  logic [15:0] lfsr = 16'hb87c;
  logic [31:0] q;
  logic [9:0] tab [6] = '{10'h007, 10'h008, 10'h201, 10'h27f, 10'h280,
                          10'h103};
  int n_mismatch = 0;
  int samples_checked = 0;
  assign ev = {multiblockStart, blockValid, lmfcEdge,
               laneChar[9:0] == 10'h0f4 || laneChar[9:0] == 10'h30b};
  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Self-synchronous descramble of a block from the previous one alone;
  // flags any tail bit of a 16-bit sample field that is not zero
  function automatic logic descr_bad(input logic [63:0] p, c);
    logic [127:0] w;
    w = {p, c};
    return |((c ^ w[102:39] ^ w[121:58]) & 64'h000f000f000f000f);
  endfunction
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    lfsr <= lfsr_step(lfsr);
    sampleData <= {lfsr, ~lfsr, lfsr ^ 16'h5a5a, lfsr};
  end
  jttl_tx_link #(.NL(4), .NBITS(12)) i_jttl_tx_link (.ref_clk(ref_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sampleData(sampleData), .sampleReady(sampleReady), .sync_n(sync_n),
    .sysref(sysref), .laneChar(laneChar), .laneBlock(laneBlock),
    .blockValid(blockValid), .multiblockStart(multiblockStart),
    .lmfcEdge(lmfcEdge));
  jttl_rx_model i_jttl_rx_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .laneChar0(laneChar[9:0]), .lmfcEdge(lmfcEdge), .linkReq(linkReq),
    .sync_n(sync_n), .sysref(sysref));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic kok(input logic [1:0] fmt, input logic [7:0] k);
    int p;
    p = (2 << (fmt % 3)) * (k + 1);
    return p >= 17 && p <= 1024;
  endfunction
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    i = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i >= 20) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge ref_clk);
  endtask
  task automatic cnt(input int b, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (ev[b] !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    logic [9:0] v;
    int n;
    int m;
    int d;
    int e;
    int r;
    logic [63:0] pb;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    bus(0, 4'h0, 0);
    check("ctrl", q, 32'h0);
    bus(0, 4'h4, 0);
    check("kcfg", q, 32'h1f);
    bus(0, 4'h8, 0);
    check("stat", q & 32'h37, 32'h10);
    bus(1, 4'hc, 32'hffffffff);
    bus(0, 4'hc, 0);
    check("unmapped", q, 32'h0);
    $display("registers done");
    for (n = 0; n < 10; n++) begin
      v = n < 6 ? tab[n] : {lfsr[9:8] % 2'd3, lfsr[7:0]};
      bus(1, 4'h0, {26'h0, v[9:8], 4'h0});
      bus(1, 4'h4, {24'h0, v[7:0]});
      bus(0, 4'h8, 0);
      check("kvalid", 32'(q[4]), 32'(kok(v[9:8], v[7:0])));
    end
    $display("k range done");
    bus(1, 4'h4, 32'h1f);
    bus(1, 4'h0, 32'h3);
    linkReq <= 1'b1;
    cnt(0, n);
    // Octet 1 of the first alignment multiframe, plain, same disparity
    v = laneChar[9:0] == 10'h0f4 ? 10'h1d4 : 10'h22b;
    @(posedge ref_clk);
    check("ilas ramp", laneChar[9:0], v);
    cnt(1, n);
    cnt(1, n);
    check("lmfc period", n, 64);
    repeat (300) @(posedge ref_clk);
    bus(0, 4'h8, 0);
    check("data state", 32'(q[2:0]), 32'h4);
    d = 0;
    e = 0;
    r = 0;
    for (m = 0; m < 16; m++) begin
      @(posedge ref_clk);
      d += $countones(laneChar[9:0]) - 5;
      e |= 32'(d > 1 || d < -1);
      r += 32'(sampleReady);
    end
    check("disparity", e, 0);
    check("sample ready", r, 8);
    // Start the resync just after an edge so none comes before the read
    cnt(1, n);
    linkReq <= 1'b0;
    @(posedge ref_clk);
    linkReq <= 1'b1;
    repeat (10) @(posedge ref_clk);
    bus(0, 4'h8, 0);
    check("resync", 32'(q[2:0]), 32'h1);
    $display("link done");
    bus(1, 4'h0, 32'h30);
    bus(1, 4'h0, 32'h31);
    bus(0, 4'h8, 0);
    check("64b", 32'(q[5]), 32'h1);
    cnt(2, n);
    pb = laneBlock[63:0];
    for (n = 0; n < 3; n++) begin
      cnt(2, m);
      check("block gap", m, 8);
      check("hdr", {laneBlock[263:262], laneBlock[65:64]}, 5);
      check("descramble", descr_bad(pb, laneBlock[63:0]), 0);
      pb = laneBlock[63:0];
    end
    cnt(3, n);
    cnt(3, n);
    check("multiblock", n, 256);
    $display("64b done");
    complete_run();
  end
endmodule
